// File: include/pwr_pkg.sv
// Behaviour
// RULE1: gating register resets to 0x67; bit 7 reserved, reads zero.
// RULE2: gating register accepts writes only while unlocked; locked writes change nothing.
// RULE3: gating bit 6 set removes clock and power from temperature sensor.
// RULE4: gating bit 5 set stops metering clock and all three converters.
// RULE5: gating bit 4 set switches off brown-out detector supply.
// RULE6: gating bit 3 set switches off low-voltage detector supply.
// RULE7: gating bit 2 set removes clock and power from display driver.
// RULE8: gating bit 1 set gates the two-wire serial unit clock.
// RULE9: gating bit 0 set gates the four-wire serial unit clock.
// RULE10: key status holds key in bits 7..2, command bit 1, companion bit 0.
// RULE11: key status is valid only when key field equals 101101.
// RULE12: trigger write 0x36 with invalid key resets the system instead.
// RULE13: valid key, command one, companion zero, then 0x36 enters power-down.
// RULE14: software writes 0x36 with valid key only using command one, companion zero.
// RULE15: trigger register is eight bits, resets zero; 0x36 with valid key enters power-down.
// RULE16: reset cause register reports five causes in bits 7..3, resets 0x80, read-only.
// RULE17: in power-down, pins, clock alarm, watchdog or reset pin cause wake reset.
// RULE18: every wake reset from power-down sets wake flag, bit 3.
// RULE19: reading reset cause register clears the wake flag after returning it.
// RULE20: a low pulse of at least 100 ns on a wake pin wakes.
// RULE21: wake reset restores all registers except reset cause, restarts processor.
// RULE22: oscillator and watchdog run in power-down only if keep-alive set before entry.
// RULE23: writes to gating or clock configuration need a software unlock first.
package pwr_pkg;
	// ---------------------------------------------------------------
	// bus and register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam int        ADDR_W          = 12;
	localparam int        DATA_W          = 32;
	localparam logic [7:0] IDX_RESET_CAUSE = 8'hB7;
	localparam logic [7:0] IDX_RC_CONTROL  = 8'hBC;
	localparam logic [7:0] IDX_CLOCK_CFG   = 8'hBD;
	localparam logic [7:0] IDX_GATING      = 8'hBF;
	localparam logic [7:0] IDX_KEY_STATUS  = 8'hC7;
	localparam logic [7:0] IDX_TRIGGER     = 8'hCF;
	localparam logic [7:0] IDX_UNLOCK      = 8'hE0;
	// ---------------------------------------------------------------
	// reset values and fields
	// ---------------------------------------------------------------
	localparam logic [7:0] GATING_RESET    = 8'h67;
	localparam logic [7:0] GATING_MASK     = 8'h7F;
	localparam int        BIT_TEMP        = 6;
	localparam int        BIT_METER       = 5;
	localparam int        BIT_BROWNOUT    = 4;
	localparam int        BIT_LOW_VOLT    = 3;
	localparam int        BIT_DISPLAY     = 2;
	localparam int        BIT_TWO_WIRE    = 1;
	localparam int        BIT_FOUR_WIRE   = 0;
	localparam logic [7:0] CLOCK_CFG_RESET = 8'h00;
	localparam logic [7:0] RC_CONTROL_RESET = 8'h00;
	localparam int        RC_KEEP_BIT     = 1;
	localparam logic [7:0] KEY_STATUS_RESET = 8'h00;
	localparam logic [5:0] KEY_VALID       = 6'h2D;
	localparam int        KEY_LSB         = 2;
	localparam int        CMD_BIT         = 1;
	localparam int        COMP_BIT        = 0;
	localparam logic [7:0] TRIGGER_RESET   = 8'h00;
	localparam logic [7:0] TRIGGER_CMD     = 8'h36;
	localparam logic [7:0] UNLOCK_KEY      = 8'hA5;
	localparam logic [7:0] CAUSE_RESET     = 8'h80;
	localparam int        CAUSE_PIN_BIT   = 6;
	localparam int        CAUSE_WDT_BIT   = 5;
	localparam int        CAUSE_BOR_BIT   = 4;
	localparam int        CAUSE_WAKE_BIT  = 3;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int        CLK_PERIOD_NS   = 50;
	localparam int        WAKE_PULSE_NS   = 100;
	localparam int        WAKE_PULSE_CYC  = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int        SYS_RESET_NS    = 200;
	localparam int        SYS_RESET_CYC   = (SYS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ---------------------------------------------------------------
	// sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_DOWN  = 3'b010,
		ST_RESET = 3'b100
	} seq_state_t;
endpackage

// File: hdl/pin_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for a pin level
module pin_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	// clock and reset
	input  logic pclk,
	input  logic presetn,
	input  logic ce,
	// level
	input  logic pin,
	output logic level
);
	logic meta;

	// ---------------------------------------------------------------
	// synchroniser
	// ---------------------------------------------------------------
	// first stage is read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta  <= RESET_LEVEL;
			level <= RESET_LEVEL;
		end else if (ce) begin
			meta  <= pin;
			level <= meta;
		end
	end
endmodule

// File: hdl/wake_pin_filter.sv
`timescale 1ns/1ns
// qualifies a low pulse on a synchronised wake pin
module wake_pin_filter (
	// clock and reset
	input  logic pclk,
	input  logic presetn,
	input  logic ce,
	// control and level
	input  logic arm,
	input  logic level,
	// result
	output logic wake
);
	import pwr_pkg::*;

	logic [1:0] low_cnt;

	// ---------------------------------------------------------------
	// low-time counter
	// ---------------------------------------------------------------
	// glitches shorter than the least pulse never wake the chip
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt <= 2'h0;
			wake    <= 1'b0;
		end else if (ce) begin
			if (!arm || level) begin
				low_cnt <= 2'h0;
			end else if (low_cnt != 2'(WAKE_PULSE_CYC)) begin
				low_cnt <= low_cnt + 2'h1;
			end
			wake <= arm && !level && (low_cnt == 2'(WAKE_PULSE_CYC - 1)); // [RULE20]
		end
	end

	a_pulse_qualified : assert property (@(posedge pclk) disable iff (!presetn)
		wake |-> $past(low_cnt) == 2'(WAKE_PULSE_CYC - 1)) else $error("wake without qualified low time"); // [RULE20]
endmodule

// File: hdl/power_down_mode_control.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ns
// power gating, keyed deep power-down entry and reset cause tracking
module power_down_mode_control (
	// clock, reset, enable
	input  logic                        pclk,
	input  logic                        presetn,
	input  logic                        ce,
	// apb slave
	input  logic                        psel,
	input  logic                        penable,
	input  logic                        pwrite,
	input  logic [pwr_pkg::ADDR_W-1:0]  paddr,
	input  logic [pwr_pkg::DATA_W-1:0]  pwdata,
	output logic [pwr_pkg::DATA_W-1:0]  prdata,
	output logic                        pready,
	output logic                        pslverr,
	// wake and reset sources
	input  logic                        external_interrupt_a_pin_n,
	input  logic                        external_interrupt_b_pin_n,
	input  logic                        serial_receive_a_pin,
	input  logic                        serial_receive_b_pin,
	input  logic                        reset_pin_n,
	input  logic                        rtc_wake,
	input  logic                        watchdog_overflow,
	input  logic                        brownout_event,
	// unit gating
	output logic                        temp_sensor_off,
	output logic                        metering_off,
	output logic                        brownout_detector_off,
	output logic                        low_voltage_detector_off,
	output logic                        display_driver_off,
	output logic                        two_wire_clock_off,
	output logic                        four_wire_clock_off,
	output logic [7:0]                  clock_configuration_out,
	// mode and reset
	output logic                        deep_power_down_mode,
	output logic                        rc_osc_enable,
	output logic                        system_reset
);
	import pwr_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [7:0]  unit_power_gating;
	logic [7:0]  clock_configuration;
	logic [7:0]  rc_control;
	logic [7:0]  power_down_key_status;
	logic [7:0]  power_down_trigger;
	logic [7:0]  reset_cause_status;
	logic        unlocked;
	seq_state_t  state, next_state;
	logic [2:0]  reset_cnt;
	logic        setup_phase, wr_access, rd_access;
	logic [7:0]  rd_val;
	logic        rd_ok;
	logic [7:0]  wbyte;
	logic        key_valid, trigger_cmd, enter_ok, enter_bad_key;
	logic        protected_wr, soft_reset;
	logic [3:0]  pin_level, pin_wake;
	logic        reset_pin_level;
	logic        wake_any, wake_set, run_reset;

	// ---------------------------------------------------------------
	// decode helper
	// ---------------------------------------------------------------
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		reg_hit = (addr == {2'b00, idx, 2'b00});
	endfunction

	// ---------------------------------------------------------------
	// wake pin synchronisers and pulse filters
	// ---------------------------------------------------------------
	// the four wake pins idle high, so the synchronisers reset high
	logic [3:0] wake_pins;
	assign wake_pins = {serial_receive_b_pin, serial_receive_a_pin,
	                    external_interrupt_b_pin_n, external_interrupt_a_pin_n};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_wake
			pin_sync #(.RESET_LEVEL(1'b1)) u_sync (
				.pclk    (pclk),
				.presetn (presetn),
				.ce      (ce),
				.pin     (wake_pins[gi]),
				.level   (pin_level[gi])
			);
			wake_pin_filter u_filter (
				.pclk    (pclk),
				.presetn (presetn),
				.ce      (ce),
				.arm     (state == ST_DOWN),
				.level   (pin_level[gi]),
				.wake    (pin_wake[gi])
			);
		end
	endgenerate

	pin_sync #(.RESET_LEVEL(1'b1)) u_rst_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.pin     (reset_pin_n),
		.level   (reset_pin_level)
	);

	// ---------------------------------------------------------------
	// bus access terms
	// ---------------------------------------------------------------
	// a transfer completes at the edge where pready is seen high
	assign setup_phase = psel && !penable;
	assign wr_access   = psel && penable && pready && pwrite;
	assign rd_access   = psel && penable && pready && !pwrite;
	assign wbyte       = pwdata[7:0];

	// keyed entry checks on the stored key status and the trigger byte being written
	assign key_valid     = power_down_key_status[7:KEY_LSB] == KEY_VALID; // [RULE11]
	assign trigger_cmd   = wr_access && reg_hit(paddr, IDX_TRIGGER) && wbyte == TRIGGER_CMD && state == ST_RUN;
	assign enter_ok      = trigger_cmd && key_valid && power_down_key_status[CMD_BIT]
	                       && !power_down_key_status[COMP_BIT]; // [RULE13] [RULE15]
	assign enter_bad_key = trigger_cmd && !key_valid; // [RULE12]
	// other combinations with a valid key are left alone; their outcome is undefined anyway
	assign protected_wr  = wr_access && (reg_hit(paddr, IDX_GATING) || reg_hit(paddr, IDX_CLOCK_CFG)
	                       || reg_hit(paddr, IDX_RC_CONTROL));
	assign soft_reset    = state == ST_RESET; // [RULE21]

	// wake sources; watchdog only counts while its oscillator is kept
	assign wake_any = (|pin_wake) || rtc_wake || (watchdog_overflow && rc_osc_enable)
	                  || !reset_pin_level; // [RULE17]
	assign wake_set  = state == ST_DOWN && wake_any;
	assign run_reset = state == ST_RUN && (!reset_pin_level || watchdog_overflow || brownout_event);

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	always_comb begin
		rd_val = 8'h00;
		rd_ok  = 1'b1;
		if (reg_hit(paddr, IDX_RESET_CAUSE)) begin
			rd_val = reset_cause_status;
		end else if (reg_hit(paddr, IDX_RC_CONTROL)) begin
			rd_val = rc_control;
		end else if (reg_hit(paddr, IDX_CLOCK_CFG)) begin
			rd_val = clock_configuration;
		end else if (reg_hit(paddr, IDX_GATING)) begin
			rd_val = unit_power_gating & GATING_MASK; // [RULE1]
		end else if (reg_hit(paddr, IDX_KEY_STATUS)) begin
			rd_val = power_down_key_status;
		end else if (reg_hit(paddr, IDX_TRIGGER)) begin
			rd_val = power_down_trigger;
		end else if (reg_hit(paddr, IDX_UNLOCK)) begin
			rd_val = {7'h00, unlocked};
		end else begin
			rd_ok = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// apb answer
	// ---------------------------------------------------------------
	// registered answer: zero wait states, data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready  <= setup_phase;
			pslverr <= setup_phase && !rd_ok;
			if (setup_phase) begin
				prdata <= {24'h000000, rd_val};
			end
		end
	end

	// ---------------------------------------------------------------
	// write unlock gate
	// ---------------------------------------------------------------
	// one unlock admits exactly one protected write, limiting runaway code damage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlocked <= 1'b0;
		end else if (ce) begin
			if (soft_reset || protected_wr) begin
				unlocked <= 1'b0; // [RULE23]
			end else if (wr_access && reg_hit(paddr, IDX_UNLOCK)) begin
				unlocked <= wbyte == UNLOCK_KEY;
			end
		end
	end

	// ---------------------------------------------------------------
	// protected registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_power_gating   <= GATING_RESET; // [RULE1]
			clock_configuration <= CLOCK_CFG_RESET;
			rc_control          <= RC_CONTROL_RESET;
		end else if (ce) begin
			if (soft_reset) begin
				unit_power_gating   <= GATING_RESET; // [RULE21]
				clock_configuration <= CLOCK_CFG_RESET;
				rc_control          <= RC_CONTROL_RESET;
			end else if (protected_wr && unlocked) begin // [RULE2] [RULE23]
				if (reg_hit(paddr, IDX_GATING)) begin
					unit_power_gating <= wbyte & GATING_MASK; // [RULE1]
				end
				if (reg_hit(paddr, IDX_CLOCK_CFG)) begin
					clock_configuration <= wbyte;
				end
				if (reg_hit(paddr, IDX_RC_CONTROL)) begin
					rc_control <= wbyte;
				end
			end
		end
	end

	// gating outputs are the register bits themselves
	assign temp_sensor_off          = unit_power_gating[BIT_TEMP];      // [RULE3]
	assign metering_off             = unit_power_gating[BIT_METER];     // [RULE4]
	assign brownout_detector_off    = unit_power_gating[BIT_BROWNOUT];  // [RULE5]
	assign low_voltage_detector_off = unit_power_gating[BIT_LOW_VOLT];  // [RULE6]
	assign display_driver_off       = unit_power_gating[BIT_DISPLAY];   // [RULE7]
	assign two_wire_clock_off       = unit_power_gating[BIT_TWO_WIRE];  // [RULE8]
	assign four_wire_clock_off      = unit_power_gating[BIT_FOUR_WIRE]; // [RULE9]
	assign clock_configuration_out  = clock_configuration;

	// ---------------------------------------------------------------
	// key status and trigger registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_down_key_status <= KEY_STATUS_RESET; // [RULE10]
			power_down_trigger    <= TRIGGER_RESET; // [RULE15]
		end else if (ce) begin
			if (soft_reset) begin
				power_down_key_status <= KEY_STATUS_RESET; // [RULE21]
				power_down_trigger    <= TRIGGER_RESET;
			end else if (wr_access) begin
				if (reg_hit(paddr, IDX_KEY_STATUS)) begin
					power_down_key_status <= wbyte; // [RULE10]
				end
				if (reg_hit(paddr, IDX_TRIGGER)) begin
					power_down_trigger <= wbyte;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// reset cause register
	// ---------------------------------------------------------------
	// survives the soft reset; a new wake wins over a clearing read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_cause_status <= CAUSE_RESET; // [RULE16]
		end else if (ce) begin
			if (wake_set) begin
				reset_cause_status[CAUSE_WAKE_BIT] <= 1'b1; // [RULE18]
			end else if (rd_access && reg_hit(paddr, IDX_RESET_CAUSE)) begin
				reset_cause_status[CAUSE_WAKE_BIT] <= 1'b0; // [RULE19]
			end
			if (state == ST_RUN && !reset_pin_level) begin
				reset_cause_status[CAUSE_PIN_BIT] <= 1'b1; // [RULE16]
			end
			if (state == ST_RUN && watchdog_overflow) begin
				reset_cause_status[CAUSE_WDT_BIT] <= 1'b1;
			end
			if (state == ST_RUN && brownout_event) begin
				reset_cause_status[CAUSE_BOR_BIT] <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// mode sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (enter_ok) begin
					next_state = ST_DOWN; // [RULE13]
				end else if (enter_bad_key || run_reset) begin
					next_state = ST_RESET; // [RULE12]
				end
			end
			ST_DOWN: begin
				if (wake_any) begin
					next_state = ST_RESET; // [RULE17]
				end
			end
			ST_RESET: begin
				if (reset_cnt == 3'(SYS_RESET_CYC - 1)) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RESET;
			end
		endcase
	end

	// state, reset counter and mode outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                <= ST_RUN;
			reset_cnt            <= 3'h0;
			deep_power_down_mode <= 1'b0;
			system_reset         <= 1'b0;
		end else if (ce) begin
			state                <= next_state;
			reset_cnt            <= (state == ST_RESET) ? reset_cnt + 3'h1 : 3'h0;
			deep_power_down_mode <= next_state == ST_DOWN;
			system_reset         <= next_state == ST_RESET; // [RULE21]
		end
	end

	// oscillator keep-alive is captured at entry and held through power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_osc_enable <= 1'b1;
		end else if (ce) begin
			if (enter_ok) begin
				rc_osc_enable <= rc_control[RC_KEEP_BIT]; // [RULE22]
			end else if (state != ST_DOWN) begin
				rc_osc_enable <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	sequence key_write_good;
		ce && enter_ok;
	endsequence
	sequence key_write_bad;
		ce && enter_bad_key;
	endsequence
	a_gating_reserved_zero : assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
		!unit_power_gating[7]) else $error("gating reserved bit set");
	a_locked_write_held : assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
		ce && wr_access && reg_hit(paddr, IDX_GATING) && !unlocked && !soft_reset
		|=> $stable(unit_power_gating)) else $error("locked gating write took effect");
	a_gating_outputs_tied : assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
		ce && !soft_reset && !(protected_wr && unlocked && reg_hit(paddr, IDX_GATING))
		|=> $stable({temp_sensor_off, metering_off, display_driver_off}))
		else $error("gating outputs changed without a write");
	a_bad_key_resets : assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
		key_write_bad |=> system_reset && !deep_power_down_mode) else $error("bad key did not reset");
	a_good_key_enters : assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
		key_write_good |=> deep_power_down_mode && !system_reset) else $error("valid entry refused");
	a_wake_to_reset : assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
		ce && state == ST_DOWN && wake_any |=> system_reset && reset_cause_status[CAUSE_WAKE_BIT])
		else $error("wake did not reset or flag");
	a_read_clears_wake : assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
		ce && rd_access && reg_hit(paddr, IDX_RESET_CAUSE) && !wake_set
		|=> !reset_cause_status[CAUSE_WAKE_BIT]) else $error("wake flag not cleared by read");
	a_soft_reset_values : assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
		ce && soft_reset |=> unit_power_gating == GATING_RESET && power_down_key_status == KEY_STATUS_RESET
		&& reset_cause_status[7] == $past(reset_cause_status[7])) else $error("soft reset values wrong");
	a_rc_keep_latched : assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
		key_write_good |=> rc_osc_enable == $past(rc_control[RC_KEEP_BIT])) else $error("keep-alive not latched");
endmodule

// File: tb/power_down_mode_control_bench.sv
`timescale 1ns/1ns
module power_down_mode_control_bench;
	import pwr_pkg::*;
	// -------------------------------------------
	// stimulus, observed outputs and counters
	// -------------------------------------------
	logic              pclk, presetn, psel, penable, pwrite, rtc, wdt, rst_pin_n, pready, err, sys_rst, pd, rc_on, bor;
	logic [3:0]        pins_n;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic [6:0]        gate;
	logic [7:0]        cfg, q, v;
	int                n_mismatch, n_tests;

	always #25 pclk = ~pclk;

	power_down_mode_control uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(err),
		.external_interrupt_a_pin_n(pins_n[0]), .external_interrupt_b_pin_n(pins_n[1]),
		.serial_receive_a_pin(pins_n[2]), .serial_receive_b_pin(pins_n[3]), .reset_pin_n(rst_pin_n),
		.rtc_wake(rtc), .watchdog_overflow(wdt), .brownout_event(bor), .temp_sensor_off(gate[6]),
		.metering_off(gate[5]), .brownout_detector_off(gate[4]), .low_voltage_detector_off(gate[3]),
		.display_driver_off(gate[2]), .two_wire_clock_off(gate[1]), .four_wire_clock_off(gate[0]),
		.clock_configuration_out(cfg), .deep_power_down_mode(pd), .rc_osc_enable(rc_on), .system_reset(sys_rst));

	// -------------------------------------------
	// shared tasks
	// -------------------------------------------
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// expected gating read-back: reserved bit 7 always reads zero
	function automatic logic [7:0] gate_exp(input logic [7:0] d);
		return d & GATING_MASK;
	endfunction

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
		if (k >= 20) chk("pready", 8'h01, 8'h00);
		q = prdata[7:0];
		psel <= 1'b0; penable <= 1'b0;
	endtask

	// waits for the soft reset pulse and measures its length
	task automatic wait_rst;
		int n;
		n = 0;
		while (sys_rst !== 1'b1 && n < 40) begin @(posedge pclk); n++; end
		n = 0;
		while (sys_rst === 1'b1 && n < 40) begin n++; @(posedge pclk); end
		chk("reset_len", 8'(SYS_RESET_CYC), 8'(n));
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// -------------------------------------------
	// main sequence
	// -------------------------------------------
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
		rtc = 0; wdt = 0; rst_pin_n = 1; pins_n = 4'hF; n_mismatch = 0; n_tests = 0; bor = 0;
		void'($urandom(73896));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(0, IDX_RESET_CAUSE, 0); chk("cause", CAUSE_RESET, q);
		apb(0, IDX_KEY_STATUS, 0); chk("key", KEY_STATUS_RESET, q);
		apb(0, IDX_TRIGGER, 0); chk("trigger", TRIGGER_RESET, q);
		apb(0, IDX_GATING, 0); chk("gating", GATING_RESET, q);
		chk("gate_out", GATING_RESET, {1'b0, gate});
		apb(1, IDX_GATING, 8'h00); apb(0, IDX_GATING, 0); chk("locked", GATING_RESET, q);
		apb(1, IDX_RESET_CAUSE, 8'hFF); apb(0, IDX_RESET_CAUSE, 0); chk("cause_wr", CAUSE_RESET, q);
		apb(0, 8'h10, 0); chk("slverr", 8'h01, {7'b0, err});
		$display("reset and access test done");
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			apb(1, IDX_UNLOCK, UNLOCK_KEY); apb(1, IDX_GATING, v); apb(0, IDX_GATING, 0);
			chk("gating_rw", gate_exp(v), q);
			chk("gate_out", gate_exp(v), {1'b0, gate});
			apb(1, IDX_UNLOCK, UNLOCK_KEY); apb(1, IDX_CLOCK_CFG, ~v);
			// the write lands at the access edge, so look one edge later
			@(posedge pclk);
			chk("cfg", ~v, cfg);
		end
		$display("gating test done");
		apb(1, IDX_TRIGGER, TRIGGER_CMD); wait_rst();
		chk("pd_bad", 8'h00, {7'b0, pd});
		apb(0, IDX_GATING, 0); chk("gating_rst", GATING_RESET, q);
		$display("bad key test done");
		// sources: four wake pins, clock alarm, watchdog (with keep-alive), reset pin
		for (int s = 0; s < 7; s++) begin
			apb(1, IDX_UNLOCK, UNLOCK_KEY); apb(1, IDX_RC_CONTROL, (s == 5) ? 8'h02 : 8'h00);
			apb(1, IDX_UNLOCK, UNLOCK_KEY); apb(1, IDX_GATING, 8'h00);
			apb(1, IDX_KEY_STATUS, {KEY_VALID, 2'b10}); apb(1, IDX_TRIGGER, TRIGGER_CMD);
			repeat (2) @(posedge pclk);
			chk("pd_enter", 8'h01, {7'b0, pd});
			chk("rc_keep", (s == 5) ? 8'h01 : 8'h00, {7'b0, rc_on});
			if (s < 4) pins_n[s] <= 1'b0;
			else if (s == 4) rtc <= 1'b1;
			else if (s == 5) wdt <= 1'b1;
			else rst_pin_n <= 1'b0;
			// two cycles low is the shortest qualifying wake pulse
			repeat (WAKE_PULSE_CYC) @(posedge pclk);
			pins_n <= 4'hF; rtc <= 1'b0; wdt <= 1'b0; rst_pin_n <= 1'b1;
			wait_rst();
			chk("pd_exit", 8'h00, {7'b0, pd});
			apb(0, IDX_GATING, 0); chk("gating_wake", GATING_RESET, q);
			apb(0, IDX_RESET_CAUSE, 0); chk("wake_flag", 8'h08, q & 8'h08);
			apb(0, IDX_RESET_CAUSE, 0); chk("wake_clr", 8'h00, q & 8'h08);
			$display("wake source %0d test done", s);
		end
		// brownout in run: soft reset and a sticky cause bit, wake bit already cleared
		bor <= 1'b1;
		@(posedge pclk);
		bor <= 1'b0;
		wait_rst();
		apb(0, IDX_RESET_CAUSE, 0); chk("cause_bor", CAUSE_RESET | (8'h01 << CAUSE_BOR_BIT), q);
		$display("brownout test done");
		final_report();
	end

	// hang guard, far beyond the length of the sequence above
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		final_report();
	end
endmodule
